//--- pkg/power_state_pkg.sv
// Shared state codes, voltage codes and widths of the power-state controller.
// Assumes a single clock domain and a strobe-style software request port.
package power_state_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int STATE_W = 4;
    localparam int WAKE_W = 8;
    localparam int VDD_W = 2;

    // ------------------------------------------------------------
    // Power states, Gray code in the order listed below
    // ------------------------------------------------------------
    typedef enum logic [STATE_W-1:0] {
        ST_FULL_ACT   = 4'h0,
        ST_FULL_STBY  = 4'h1,
        ST_RED_ACT    = 4'h3,
        ST_RED_STBY   = 4'h2,
        ST_LOW_ACT    = 4'h6,
        ST_LOW_STBY   = 4'h7,
        ST_PERIPH_ACT = 4'h5,
        ST_FULL_SLP   = 4'h4,
        ST_RED_SLP    = 4'hC,
        ST_LOW_SLP    = 4'hD,
        ST_DEEP       = 4'hF
    } pwr_state_e;

    // ------------------------------------------------------------
    // Main SRAM / core supply level codes
    // ------------------------------------------------------------
    localparam logic [VDD_W-1:0] VDD_OFF = 2'h0;
    localparam logic [VDD_W-1:0] VDD_LOW = 2'h1;
    localparam logic [VDD_W-1:0] VDD_MID = 2'h2;
    localparam logic [VDD_W-1:0] VDD_HIGH = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam pwr_state_e RST_STATE = ST_FULL_ACT;
    localparam logic [WAKE_W-1:0] RST_WAKE_MASK = 8'h00;

endpackage : power_state_pkg

//--- rtl/app_cpu_power_state_ctrl.sv
// Power-state controller of the application processor subsystem.
// Assumes synchronous request/wfi strobes and level interrupt inputs.
`timescale 1ns/1ps
`default_nettype none

module app_cpu_power_state_ctrl
    import power_state_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wait_irq,
    input wire logic i_sw_req,
    input wire logic [STATE_W-1:0] i_sw_target,
    input wire logic [WAKE_W-1:0] i_wake_enable,
    input wire logic [WAKE_W-1:0] i_wake_irq,
    output logic [STATE_W-1:0] o_power_state,
    output logic o_cpu_clk_en,
    output logic o_cpu_pwr_on,
    output logic o_full_func,
    output logic o_periph_pwr_on,
    output logic o_low_power_domain_on,
    output logic o_battery_gpio_on,
    output logic o_sram_pwr_on,
    output logic o_sram_retain,
    output logic [VDD_W-1:0] o_sram_vdd_sel
);

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    pwr_state_e state_r;
    pwr_state_e state_nxt;
    pwr_state_e tgt_w;
    pwr_state_e stby_of_w;
    pwr_state_e slp_of_w;
    pwr_state_e act_of_w;
    logic cpu_act_w;
    logic active_w;
    logic stby_w;
    logic slp_w;
    logic lowpwr_w;
    logic tgt_active_w;
    logic req_ok_w;
    logic enter_low_w;
    logic wake_w;

    assign tgt_w = pwr_state_e'(i_sw_target);
    assign cpu_act_w = (state_r == ST_FULL_ACT) || (state_r == ST_RED_ACT)
                       || (state_r == ST_LOW_ACT);
    assign active_w = cpu_act_w || (state_r == ST_PERIPH_ACT);
    assign stby_w = (state_r == ST_FULL_STBY) || (state_r == ST_RED_STBY)
                    || (state_r == ST_LOW_STBY);
    assign slp_w = (state_r == ST_FULL_SLP) || (state_r == ST_RED_SLP)
                   || (state_r == ST_LOW_SLP);
    assign lowpwr_w = stby_w || slp_w || (state_r == ST_DEEP);
    assign tgt_active_w = (tgt_w == ST_FULL_ACT) || (tgt_w == ST_RED_ACT)
                          || (tgt_w == ST_LOW_ACT) || (tgt_w == ST_PERIPH_ACT);

    // Matching standby / sleep of the current active state
    assign stby_of_w = (state_r == ST_FULL_ACT) ? ST_FULL_STBY :
                       (state_r == ST_RED_ACT) ? ST_RED_STBY : ST_LOW_STBY;
    assign slp_of_w = (state_r == ST_FULL_ACT) ? ST_FULL_SLP :
                      (state_r == ST_RED_ACT) ? ST_RED_SLP : ST_LOW_SLP;
    // Active state to return to from standby or sleep
    assign act_of_w = ((state_r == ST_FULL_STBY) || (state_r == ST_FULL_SLP)) ? ST_FULL_ACT :
                      ((state_r == ST_RED_STBY) || (state_r == ST_RED_SLP)) ? ST_RED_ACT :
                      ST_LOW_ACT;

    // deep from any active state, peripheral-only included
    // Illegal targets are dropped silently; status shows no change
    assign req_ok_w = i_sw_req && active_w
                      && (tgt_active_w || (tgt_w == ST_DEEP)
                          || (cpu_act_w && (tgt_w == slp_of_w)));

    // Wait-irq entry must capture too, whatever target is left on the bus
    assign enter_low_w = active_w && (state_nxt != state_r)
                         && !(state_nxt == ST_FULL_ACT) && !(state_nxt == ST_RED_ACT)
                         && !(state_nxt == ST_LOW_ACT) && !(state_nxt == ST_PERIPH_ACT);

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    wake_gate u_wake_gate (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_capture(enter_low_w),
        .i_armed(lowpwr_w),
        .i_enable(i_wake_enable),
        .i_irq(i_wake_irq),
        .o_wake(wake_w)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_FULL_ACT, ST_RED_ACT, ST_LOW_ACT:
            begin
                if (i_wait_irq)
                    state_nxt = stby_of_w;
                else if (req_ok_w)
                    state_nxt = tgt_w;
            end
            ST_PERIPH_ACT:
            begin
                // Core is off here, so wait-irq is ignored
                if (req_ok_w)
                    state_nxt = tgt_w;
            end
            ST_FULL_STBY, ST_RED_STBY, ST_LOW_STBY,
            ST_FULL_SLP, ST_RED_SLP, ST_LOW_SLP:
            begin
                if (wake_w)
                    state_nxt = act_of_w;
            end
            ST_DEEP:
            begin
                // Nothing retained, so restart at full power
                if (wake_w)
                    state_nxt = ST_FULL_ACT;
            end
            default:
            begin
                state_nxt = RST_STATE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output decode from next state
    // ------------------------------------------------------------
    logic cpu_clk_nxt;
    logic cpu_pwr_nxt;
    logic full_func_nxt;
    logic periph_nxt;
    logic lpd_nxt;
    logic sram_pwr_nxt;
    logic sram_ret_nxt;
    logic [VDD_W-1:0] vdd_nxt;

    assign cpu_clk_nxt = (state_nxt == ST_FULL_ACT) || (state_nxt == ST_RED_ACT)
                         || (state_nxt == ST_LOW_ACT);
    assign cpu_pwr_nxt = cpu_clk_nxt || (state_nxt == ST_FULL_STBY)
                         || (state_nxt == ST_RED_STBY) || (state_nxt == ST_LOW_STBY);
    assign full_func_nxt = (state_nxt == ST_FULL_ACT) || (state_nxt == ST_RED_ACT)
                           || (state_nxt == ST_FULL_STBY) || (state_nxt == ST_RED_STBY);
    assign periph_nxt = full_func_nxt;
    assign lpd_nxt = cpu_pwr_nxt || (state_nxt == ST_PERIPH_ACT);
    assign sram_pwr_nxt = (state_nxt != ST_DEEP);
    assign sram_ret_nxt = (state_nxt == ST_FULL_SLP) || (state_nxt == ST_RED_SLP)
                          || (state_nxt == ST_LOW_SLP) || (state_nxt == ST_PERIPH_ACT);
    assign vdd_nxt = ((state_nxt == ST_FULL_ACT) || (state_nxt == ST_FULL_STBY)
                      || (state_nxt == ST_FULL_SLP)) ? VDD_HIGH :
                     ((state_nxt == ST_RED_ACT) || (state_nxt == ST_RED_STBY)
                      || (state_nxt == ST_RED_SLP)) ? VDD_MID :
                     (state_nxt == ST_DEEP) ? VDD_OFF : VDD_LOW;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= RST_STATE;
            o_power_state <= RST_STATE;
            o_cpu_clk_en <= 1'b1;
            o_cpu_pwr_on <= 1'b1;
            o_full_func <= 1'b1;
            o_periph_pwr_on <= 1'b1;
            o_low_power_domain_on <= 1'b1;
            o_battery_gpio_on <= 1'b1;
            o_sram_pwr_on <= 1'b1;
            o_sram_retain <= 1'b0;
            o_sram_vdd_sel <= VDD_HIGH;
        end
        else
        begin
            state_r <= state_nxt;
            o_power_state <= state_nxt;
            o_cpu_clk_en <= cpu_clk_nxt;
            o_cpu_pwr_on <= cpu_pwr_nxt;
            o_full_func <= full_func_nxt;
            o_periph_pwr_on <= periph_nxt;
            o_low_power_domain_on <= lpd_nxt;
            o_battery_gpio_on <= 1'b1;
            o_sram_pwr_on <= sram_pwr_nxt;
            o_sram_retain <= sram_ret_nxt;
            o_sram_vdd_sel <= vdd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    logic seen_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            seen_r <= 1'b0;
        else
            seen_r <= 1'b1;
    end

    AST_RESET_FULL:
        assert property (!seen_r |-> (o_power_state == ST_FULL_ACT) && o_full_func)
        else $error("not full power after reset");
    AST_RED_FUNC:
        assert property ((o_power_state == ST_RED_ACT) |-> o_full_func
                         && (o_sram_vdd_sel == VDD_MID))
        else $error("reduced state lost function or voltage");
    AST_LOW_LIMIT:
        assert property ((o_power_state == ST_LOW_ACT) |-> !o_full_func
                         && (o_sram_vdd_sel == VDD_LOW) && o_cpu_clk_en)
        else $error("low state wrong");
    AST_PERIPH_OFF:
        assert property ((o_power_state == ST_PERIPH_ACT) |-> !o_cpu_pwr_on
                         && !o_periph_pwr_on && o_low_power_domain_on)
        else $error("peripheral-only state wrong");
    AST_STBY_CLK:
        assert property (stby_w |-> !o_cpu_clk_en && o_cpu_pwr_on)
        else $error("standby clock not gated");
    AST_STBY_ENTRY:
        assert property ((stby_w && !$past(stby_w)) |-> $past(i_wait_irq)
                         && $past(cpu_act_w))
        else $error("standby entered without wait-irq");
    AST_STBY_KEEP:
        assert property ((stby_w && !$past(stby_w)) |-> o_sram_vdd_sel == $past(o_sram_vdd_sel)
                         && o_full_func == $past(o_full_func))
        else $error("standby changed domains");
    AST_STBY_WAKE:
        assert property ((stby_w && wake_w) |=> cpu_act_w
                         && (o_sram_vdd_sel == $past(o_sram_vdd_sel)))
        else $error("standby did not wake");
    AST_SLP_ENTRY:
        assert property ((slp_w && !$past(slp_w)) |-> $past(i_sw_req) && !o_cpu_pwr_on)
        else $error("sleep entered without request");
    AST_SLP_RETAIN:
        assert property (slp_w |-> o_sram_retain && o_sram_pwr_on && o_battery_gpio_on)
        else $error("sleep lost SRAM");
    AST_DEEP_GATE:
        assert property ((o_power_state == ST_DEEP) |-> !o_sram_pwr_on && !o_cpu_pwr_on
                         && o_battery_gpio_on)
        else $error("deep sleep not gated");
    AST_ACT_HOLD:
        assert property ((active_w && !i_sw_req && !i_wait_irq) |=> $stable(o_power_state))
        else $error("active state left without software");
    AST_NO_SPURIOUS:
        assert property ((lowpwr_w && !wake_w) |=> $stable(o_power_state))
        else $error("low-power state left without wake");

    COV_STBY_TRIP: cover property (cpu_act_w ##1 stby_w ##1 stby_w);
    COV_SLP_TRIP: cover property (slp_w ##1 cpu_act_w);
    COV_DEEP_WAKE: cover property ((o_power_state == ST_DEEP) ##1 (o_power_state == ST_FULL_ACT));
    COV_PERIPH: cover property (o_power_state == ST_PERIPH_ACT);

endmodule : app_cpu_power_state_ctrl

`default_nettype wire

//--- rtl/wake_gate.sv
// Wake detector: snapshots the wake enables on entry to a low-power state.
// Assumes the owner raises i_capture in the entry cycle and i_armed while asleep.
`timescale 1ns/1ps
`default_nettype none

module wake_gate
    import power_state_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_capture,
    input wire logic i_armed,
    input wire logic [WAKE_W-1:0] i_enable,
    input wire logic [WAKE_W-1:0] i_irq,
    output logic o_wake
);

    logic [WAKE_W-1:0] mask_r;
    logic wake_r;
    logic [WAKE_W-1:0] hit_w;

    // Enables changed while asleep do not count
    assign hit_w = i_irq & mask_r;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mask_r <= RST_WAKE_MASK;
            wake_r <= 1'b0;
        end
        else
        begin
            if (i_capture)
            begin
                mask_r <= i_enable;
            end
            wake_r <= i_armed & (|hit_w);
        end
    end

    assign o_wake = wake_r;

endmodule : wake_gate

`default_nettype wire

//--- tb/app_cpu_power_state_ctrl_tb.sv
// Self-checking bench of the power-state controller.
// Assumes the package codes and one-cycle request answers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module app_cpu_power_state_ctrl_tb;
    import power_state_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wait_irq = 1'b0;
    logic sw_req = 1'b0;
    logic [STATE_W-1:0] target = 4'h0;
    logic [WAKE_W-1:0] wake_en = 8'h00;
    logic fire = 1'b0;
    logic [WAKE_W-1:0] src = 8'h00;
    logic [WAKE_W-1:0] irq;
    logic [STATE_W-1:0] st;
    logic clk_en, cpu_pwr, ffunc, periph, lpd, bat, sram_pwr, retain;
    logic [VDD_W-1:0] vdd;
    int miscompares = 0;
    int checked = 0;

    always #5 clk = ~clk;

    wake_source_model #(.DLY(3)) u_src (.i_ref_clk(clk), .i_rst_n(rst_n), .i_fire(fire),
        .i_src(src), .o_irq(irq));

    app_cpu_power_state_ctrl u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wait_irq(wait_irq),
        .i_sw_req(sw_req), .i_sw_target(target), .i_wake_enable(wake_en), .i_wake_irq(irq),
        .o_power_state(st), .o_cpu_clk_en(clk_en), .o_cpu_pwr_on(cpu_pwr),
        .o_full_func(ffunc), .o_periph_pwr_on(periph), .o_low_power_domain_on(lpd),
        .o_battery_gpio_on(bat), .o_sram_pwr_on(sram_pwr), .o_sram_retain(retain),
        .o_sram_vdd_sel(vdd));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Flags: clk_en, cpu_pwr, full_func, lpd, sram_pwr, retain
    task automatic look(input logic [3:0] s, input logic [5:0] f, input logic [1:0] v);
        `CHK(st, s)
        `CHK({clk_en, cpu_pwr, ffunc, lpd, sram_pwr, retain}, f)
        `CHK(periph, f[3])
        `CHK(vdd, v)
        `CHK(bat, 1'b1)
    endtask : look

    task automatic req(input logic [3:0] t);
        @(posedge clk);
        sw_req <= 1'b1;
        target <= t;
        @(posedge clk);
        sw_req <= 1'b0;
        #1;
    endtask : req

    task automatic wait_irq_instruction;
        @(posedge clk);
        wait_irq <= 1'b1;
        @(posedge clk);
        wait_irq <= 1'b0;
        #1;
    endtask : wait_irq_instruction

    // Raise a source and wait for the active state to come back
    task automatic wake(input logic [7:0] s, input logic [3:0] back);
        int n;
        @(posedge clk);
        src <= s;
        fire <= 1'b1;
        n = 0;
        while (st !== back && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (st !== back)
        begin
            miscompares++;
            end_sim();
        end
        else
        begin
            @(posedge clk);
            fire <= 1'b0;
            #1;
        end
    endtask : wake

    // Raise a source for a fixed window; no wake is expected
    task automatic quiet(input logic [7:0] s);
        @(posedge clk);
        src <= s;
        fire <= 1'b1;
        repeat (10) @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
    endtask : quiet

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_active;
        req(ST_RED_ACT);
        look(ST_RED_ACT, 6'b111110, VDD_MID);
        req(ST_LOW_ACT);
        look(ST_LOW_ACT, 6'b110110, VDD_LOW);
        `CHK(sram_pwr, 1'b1)
        req(ST_PERIPH_ACT);
        look(ST_PERIPH_ACT, 6'b000111, VDD_LOW);
        wait_irq_instruction();
        `CHK(st, ST_PERIPH_ACT)
        req(ST_FULL_STBY);
        `CHK(st, ST_PERIPH_ACT)
        req(ST_FULL_ACT);
        look(ST_FULL_ACT, 6'b111110, VDD_HIGH);
        // Enabled source while active must not move it
        wake_en <= 8'hFF;
        quiet(8'hFF);
        `CHK(st, ST_FULL_ACT)
        `CHK(sram_pwr, 1'b1)
    endtask : t_active

    task automatic t_standby(input logic [3:0] a, input logic [3:0] s, input logic [5:0] f,
        input logic [1:0] v);
        req(a);
        wake_en <= 8'h04;
        wait_irq_instruction();
        look(s, f & 6'b011111, v);
        wake_en <= 8'hFF;
        req(ST_FULL_ACT);
        `CHK(st, s)
        quiet(8'h01);
        `CHK(st, s)
        wake(8'h04, a);
        look(a, f, v);
    endtask : t_standby

    task automatic t_sleep(input logic [3:0] a, input logic [3:0] s, input logic [1:0] v);
        req(a);
        req(a == ST_FULL_ACT ? ST_RED_SLP : ST_FULL_SLP);
        `CHK(st, a)
        wake_en <= 8'h80;
        req(s);
        look(s, 6'b000011, v);
        wake(8'h80, a);
        `CHK(st, a)
    endtask : t_sleep

    task automatic t_deep(input logic [3:0] a);
        req(a);
        wake_en <= 8'h10;
        req(ST_DEEP);
        look(ST_DEEP, 6'b000000, VDD_OFF);
        req(ST_FULL_ACT);
        `CHK(st, ST_DEEP)
        wake(8'h10, ST_FULL_ACT);
        look(ST_FULL_ACT, 6'b111110, VDD_HIGH);
    endtask : t_deep

    // Reset from standby must land in full power again
    task automatic t_reset;
        req(ST_LOW_ACT);
        wait_irq_instruction();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        look(ST_FULL_ACT, 6'b111110, VDD_HIGH);
    endtask : t_reset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        look(ST_FULL_ACT, 6'b111110, VDD_HIGH);
        t_active();
        t_standby(ST_FULL_ACT, ST_FULL_STBY, 6'b111110, VDD_HIGH);
        t_standby(ST_RED_ACT, ST_RED_STBY, 6'b111110, VDD_MID);
        t_standby(ST_LOW_ACT, ST_LOW_STBY, 6'b110110, VDD_LOW);
        t_sleep(ST_FULL_ACT, ST_FULL_SLP, VDD_HIGH);
        t_sleep(ST_RED_ACT, ST_RED_SLP, VDD_MID);
        t_sleep(ST_LOW_ACT, ST_LOW_SLP, VDD_LOW);
        t_deep(ST_PERIPH_ACT);
        t_deep(ST_LOW_ACT);
        t_reset();
        end_sim();
    end
endmodule : app_cpu_power_state_ctrl_tb
`default_nettype wire

//--- tb/wake_source_model.sv
// Always-on wake sources facing the power-state controller.
// Assumes the bench holds i_fire high until it has seen the wake.
`timescale 1ns/1ps
`default_nettype none

module wake_source_model
    import power_state_pkg::*;
#(
    parameter int DLY = 3
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_fire,
    input wire logic [WAKE_W-1:0] i_src,
    output logic [WAKE_W-1:0] o_irq
);
    // ------------------------------------------------------------
    // Level source with a set-up delay
    // ------------------------------------------------------------
    int cnt_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_r <= 0;
            o_irq <= 8'h00;
        end
        else if (!i_fire)
        begin
            cnt_r <= 0;
            o_irq <= 8'h00;
        end
        else if (cnt_r < DLY)
            cnt_r <= cnt_r + 1;
        else
            o_irq <= i_src;
    end
endmodule : wake_source_model
`default_nettype wire
